// *** ptcs_pkg.sv ***
// package: register map, field layout, modes and timing constants of the stamp clock
package ptcs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int              CLK_PERIOD_NS   = 4;        // ref_clk at 250 MHz
  localparam int              PULSE_WIDTH_NS  = 1000;     // width of stretched sync pulses
  localparam int              PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned LOSS_TIMEOUT_MS = 2000;     // no reference for this long: unlocked
  localparam longint unsigned LOSS_CYC        = (LOSS_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************
  // time format
  // ****************************************
  localparam int          SUB_BITS       = 24;            // hidden fraction below 2^-32 s
  localparam logic [31:0] INCR_DEFAULT   = 32'h112e_07e8; // 1024 below 2^56 / 250e6, units of 2^-56 s
  localparam logic [31:0] NS_PER_SEC     = 32'h3b9a_ca00;
  localparam logic [31:0] THRESH_DEFAULT = 32'h0000_0254; // 596 ns
  localparam int          GAIN_SHIFT     = 4;             // frequency trim gain, 1/16

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_THRESH   = 8'h04;
  localparam logic [7:0] OFS_SET_SECS = 8'h08;
  localparam logic [7:0] OFS_SET_FRAC = 8'h0c;
  localparam logic [7:0] OFS_TIME_SEC = 8'h10;
  localparam logic [7:0] OFS_TIME_FRC = 8'h14;
  localparam logic [7:0] OFS_INCR     = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_TOTAL    = 8'h20;
  localparam logic [7:0] OFS_BAD      = 8'h24;
  localparam logic [7:0] OFS_RESYNC   = 8'h28;
  localparam logic [7:0] OFS_PHASE    = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h38;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int          CTRL_MUXIN_LSB  = 0;  // 2 bits
  localparam int          CTRL_MUXOUT_LSB = 2;  // 2 bits
  localparam int          CTRL_TAIL_BIT   = 4;
  localparam int          CTRL_SET_BIT    = 8;
  localparam int          CTRL_RESET_BIT  = 9;
  localparam int          CTRL_CLEAR_BIT  = 10;
  localparam int          CTRL_TICK_BIT   = 11;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  // interrupt status bits
  localparam int IRQ_PULSE  = 0;
  localparam int IRQ_BAD    = 1;
  localparam int IRQ_RESYNC = 2;
  localparam int IRQ_LOST   = 3;
  localparam int IRQ_W      = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {IN_DIFF, IN_INTERNAL, IN_NONE} ptcs_muxin_t;
  typedef enum logic [1:0] {OUT_NONE, OUT_REPEAT, OUT_LOOP, OUT_MASTER} ptcs_muxout_t;

  typedef struct packed {
    logic [31:0] secs;
    logic [31:0] frac;
  } ptcs_stamp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } ptcs_wphase_t;

endpackage

// *** ptcs_pulse_in.sv ***
// module: synchroniser and rising-edge detector for the differential pulse input
`timescale 1ns/1ps
`default_nettype none

module ptcs_pulse_in
  import ptcs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic differentialPulseInput,
  output var  logic pulseLevel,
  output var  logic pulseRise
);

  logic metaQ;
  logic syncQ;
  logic prevQ;

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  // metaQ feeds syncQ only; everything downstream looks at syncQ
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      metaQ <= 1'b0;
      syncQ <= 1'b0;
    end else begin
      metaQ <= differentialPulseInput;
      syncQ <= metaQ;
    end
  end

  // edge detect one stage later, so the edge is glitch free
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevQ <= 1'b0;
    end else begin
      prevQ <= syncQ;
    end
  end

  assign pulseLevel = syncQ;
  assign pulseRise  = syncQ & ~prevQ;

  rise_one_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
    pulseRise |=> !pulseRise)
    else $error("pulse edge lasted more than one cycle");

endmodule // ptcs_pulse_in

`default_nettype wire

// *** ptcs_top.sv ***
// module: packet timestamp clock with sync discipline and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module ptcs_top
  import ptcs_pkg::*;
#(
  parameter int          ZERO_BITS   = 4,
  parameter int unsigned LOSS_CYCLES = 32'(LOSS_CYC)
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  // capture path
  input  wire logic        pktHead,
  input  wire logic        pktTail,
  output var  ptcs_stamp_t stampData,
  output var  logic        stampValid,
  // sync connector, circuit A
  input  wire logic        differentialPulseInput,
  output var  logic        pulseRepeatOutput,
  output var  logic        pulseRepeatOutputEn,
  output var  logic        irq
);

  localparam logic [31:0] ZERO_MASK = ~((32'h1 << ZERO_BITS) - 32'h1);

  ptcs_wphase_t        wrQ;
  ptcs_muxin_t         muxInQ;
  ptcs_muxout_t        muxOutQ;
  logic                tailSelQ;
  logic [31:0]         threshQ, setSecsQ, setFracQ, incrQ, fracShadowQ;
  logic [31:0]         secsQ, fracQ;
  logic [SUB_BITS-1:0] subQ;
  logic                syncedQ;
  logic [31:0]         lossCntQ, totalCntQ, badCntQ, resyncCntQ, lastErrQ;
  logic [IRQ_W-1:0]    irqStatQ, irqEnQ, irqEvt, irqClr;
  logic [31:0]         rdMux;
  logic                diffLevel, diffRise;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic addrAcc;
  logic wrEn;
  logic ctrlWr;
  assign addrAcc = hsel && htrans[1] && hready;
  assign wrEn    = wrQ.valid;
  assign ctrlWr  = wrEn && (wrQ.addr == OFS_CTRL);

  // zero wait state, always okay; writes land at the end of the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrQ       <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrQ.valid <= addrAcc && hwrite && (hsize == HSIZE_WORD);
      wrQ.addr  <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is taken in the address phase so it stands for the whole data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata      <= '0;
      fracShadowQ <= '0;
    end else if (addrAcc && !hwrite) begin
      hrdata <= rdMux;
      // reading whole seconds freezes the fraction, so a pair of reads never tears
      if (haddr[7:0] == OFS_TIME_SEC) begin
        fracShadowQ <= fracQ;
      end
    end
  end

  // register read mux, unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    case (haddr[7:0])
      OFS_CTRL: begin
        rdMux[CTRL_MUXIN_LSB +: 2]  = muxInQ;
        rdMux[CTRL_MUXOUT_LSB +: 2] = muxOutQ;
        rdMux[CTRL_TAIL_BIT]        = tailSelQ;
      end
      OFS_THRESH:   rdMux = threshQ;
      OFS_SET_SECS: rdMux = setSecsQ;
      OFS_SET_FRAC: rdMux = setFracQ;
      OFS_TIME_SEC: rdMux = secsQ;
      OFS_TIME_FRC: rdMux = fracShadowQ;
      OFS_INCR:     rdMux = incrQ;
      OFS_STATUS:   rdMux = {31'h0, syncedQ};
      OFS_TOTAL:    rdMux = totalCntQ;
      OFS_BAD:      rdMux = badCntQ;
      OFS_RESYNC:   rdMux = resyncCntQ;
      OFS_PHASE:    rdMux = lastErrQ;
      OFS_IRQ_STAT: rdMux = {{(32-IRQ_W){1'b0}}, irqStatQ};
      OFS_IRQ_EN:   rdMux = {{(32-IRQ_W){1'b0}}, irqEnQ};
      default:      rdMux = '0;
    endcase
  end

  // command strobes from the control register
  logic setCmd, resetCmd, clearCmd, intTick;
  assign setCmd   = ctrlWr && hwdata[CTRL_SET_BIT];
  assign resetCmd = ctrlWr && hwdata[CTRL_RESET_BIT];
  assign clearCmd = ctrlWr && hwdata[CTRL_CLEAR_BIT];
  assign intTick  = ctrlWr && hwdata[CTRL_TICK_BIT];  // host-referenced second tick

  // ****************************************
  // configuration registers
  // ****************************************
  // selector settings are volatile; rst restores all three, the reset command only the input and output selectors
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      muxInQ   <= IN_DIFF;
      muxOutQ  <= OUT_NONE;
      tailSelQ <= 1'b0;
    end else if (resetCmd) begin
      muxInQ  <= IN_DIFF;
      muxOutQ <= OUT_NONE;
    end else if (ctrlWr && !setCmd) begin
      muxInQ   <= ptcs_muxin_t'(hwdata[CTRL_MUXIN_LSB +: 2]);
      muxOutQ  <= ptcs_muxout_t'(hwdata[CTRL_MUXOUT_LSB +: 2]);
      tailSelQ <= hwdata[CTRL_TAIL_BIT];
    end
  end

  // plain data registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      threshQ  <= THRESH_DEFAULT;
      setSecsQ <= '0;
      setFracQ <= '0;
    end else if (wrEn) begin
      if (wrQ.addr == OFS_THRESH)   threshQ  <= hwdata;
      if (wrQ.addr == OFS_SET_SECS) setSecsQ <= hwdata;
      if (wrQ.addr == OFS_SET_FRAC) setFracQ <= hwdata;
    end
  end

  // ****************************************
  // time of day
  // ****************************************
  logic [56:0] accSum;
  logic        secCarry;
  logic        refEvt;
  logic        stepNow;
  assign accSum   = {1'b0, fracQ, subQ} + {25'h0, incrQ};
  assign secCarry = accSum[56];

  // reference pulse from whichever source the input selector picks
  always_comb begin
    case (muxInQ)
      IN_DIFF:     refEvt = diffRise;
      IN_INTERNAL: refEvt = intTick;
      default:     refEvt = 1'b0;      // no input: free running
    endcase
  end
  assign stepNow = refEvt && !syncedQ;

  // host load wins; a step snaps to the nearest second boundary
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      secsQ <= '0;
      fracQ <= '0;
      subQ  <= '0;
    end else if (setCmd || resetCmd) begin
      secsQ <= setSecsQ;
      fracQ <= setFracQ;
      subQ  <= '0;
    end else if (stepNow) begin
      secsQ <= fracQ[31] ? secsQ + 32'h1 : secsQ;
      fracQ <= '0;
      subQ  <= '0;
    end else begin
      secsQ <= secsQ + {31'h0, secCarry};
      fracQ <= accSum[55:24];
      subQ  <= accSum[SUB_BITS-1:0];
    end
  end

  // ****************************************
  // discipline
  // ****************************************
  logic [31:0] absErr, errNs;
  logic [63:0] errProd;
  logic        badPulse, lostEvt;
  assign absErr   = fracQ[31] ? (32'h0 - fracQ) : fracQ;
  assign errProd  = {32'h0, absErr} * {32'h0, NS_PER_SEC};
  assign errNs    = errProd[63:32];
  assign badPulse = errNs > threshQ;
  assign lostEvt  = syncedQ && !refEvt && (lossCntQ == 32'(LOSS_CYCLES - 1));

  // lock state: first pulse steps and locks, a bad pulse or silence unlocks
  always_ff @(posedge ref_clk) begin
    if (rst || resetCmd) begin
      syncedQ  <= 1'b0;
      lossCntQ <= '0;
    end else if (refEvt) begin
      syncedQ  <= !syncedQ || !badPulse;
      lossCntQ <= '0;
    end else if (muxInQ == IN_NONE || lostEvt) begin
      syncedQ  <= 1'b0;
      lossCntQ <= '0;
    end else begin
      lossCntQ <= syncedQ ? lossCntQ + 32'h1 : '0;
    end
  end

  // frequency trim on good pulses; a fast clock is ahead, so slow it down
  always_ff @(posedge ref_clk) begin
    if (rst || resetCmd) begin
      incrQ    <= INCR_DEFAULT;
      lastErrQ <= '0;
    end else if (wrEn && wrQ.addr == OFS_INCR) begin
      incrQ <= hwdata;
    end else if (refEvt) begin
      lastErrQ <= fracQ;
      if (syncedQ && !badPulse) begin
        incrQ <= incrQ - $unsigned($signed(fracQ) >>> GAIN_SHIFT);
      end
    end
  end

  // statistics; a count in the clearing cycle survives as one
  logic incTotal, incBad, incResync;
  assign incTotal  = refEvt;
  assign incBad    = refEvt && syncedQ && badPulse;
  assign incResync = stepNow;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      totalCntQ  <= '0;
      badCntQ    <= '0;
      resyncCntQ <= '0;
    end else begin
      totalCntQ  <= (clearCmd ? 32'h0 : totalCntQ) + {31'h0, incTotal};
      badCntQ    <= (clearCmd ? 32'h0 : badCntQ) + {31'h0, incBad};
      resyncCntQ <= (clearCmd ? 32'h0 : resyncCntQ) + {31'h0, incResync};
    end
  end

  // ****************************************
  // timestamp capture
  // ****************************************
  // byte 0 of the little-endian stamp is stampData[7:0], the lowest fraction byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stampData  <= '0;
      stampValid <= 1'b0;
    end else begin
      stampValid <= tailSelQ ? pktTail : pktHead;
      if (tailSelQ ? pktTail : pktHead) begin
        stampData.secs <= secsQ;
        stampData.frac <= fracQ & ZERO_MASK;
      end
    end
  end

  // ****************************************
  // sync output
  // ****************************************
  ptcs_pulse_in u_pulse_in (
    .ref_clk                (ref_clk),
    .rst                    (rst),
    .differentialPulseInput (differentialPulseInput),
    .pulseLevel             (diffLevel),
    .pulseRise              (diffRise)
  );

  // stretchers: [0] internal tick, [1] own seconds carry; one clock edge is too short
  logic [1:0] stretchTrig, stretched;
  assign stretchTrig = {secCarry, intTick};
  for (genvar g = 0; g < 2; g++) begin : g_stretch
    logic [15:0] cntQ;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cntQ <= '0;
      end else if (stretchTrig[g]) begin
        cntQ <= 16'(PULSE_WIDTH_CYC - 1);
      end else if (cntQ != 16'h0) begin
        cntQ <= cntQ - 16'h1;
      end
    end
    assign stretched[g] = stretchTrig[g] || (cntQ != 16'h0);
  end

  // output source select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulseRepeatOutput   <= 1'b0;
      pulseRepeatOutputEn <= 1'b0;
    end else begin
      pulseRepeatOutputEn <= (muxOutQ != OUT_NONE);
      case (muxOutQ)
        OUT_REPEAT: pulseRepeatOutput <= diffLevel;
        OUT_LOOP: begin
          case (muxInQ)
            IN_DIFF:     pulseRepeatOutput <= diffLevel;
            IN_INTERNAL: pulseRepeatOutput <= stretched[0];
            default:     pulseRepeatOutput <= 1'b0;
          endcase
        end
        OUT_MASTER: pulseRepeatOutput <= stretched[1];
        default:    pulseRepeatOutput <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign irqEvt = {lostEvt, incResync, incBad, refEvt};
  assign irqClr = (wrEn && wrQ.addr == OFS_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;

  // a new event in the clearing cycle stays set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStatQ <= '0;
      irqEnQ   <= '0;
      irq      <= 1'b0;
    end else begin
      irqStatQ <= (irqStatQ & ~irqClr) | irqEvt;
      if (wrEn && wrQ.addr == OFS_IRQ_EN) irqEnQ <= hwdata[IRQ_W-1:0];
      irq <= |(irqStatQ & irqEnQ);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  time_monotonic_a: assert property (!(setCmd || resetCmd || stepNow)
    |=> {secsQ, fracQ} > $past({secsQ, fracQ}))
    else $error("free-running time did not advance");
  stamp_capture_a: assert property ((tailSelQ ? pktTail : pktHead)
    |=> stampValid && stampData.secs == $past(secsQ))
    else $error("stamp not taken on selected packet edge");
  stamp_low_zero_a: assert property (stampValid
    |-> stampData.frac[ZERO_BITS-1:0] == '0)
    else $error("unresolved fraction bits not zero");
  out_none_a: assert property (muxOutQ == OUT_NONE |=> !pulseRepeatOutputEn)
    else $error("sync output driven while disabled");
  repeat_copy_a: assert property (muxOutQ == OUT_REPEAT
    |=> pulseRepeatOutputEn && pulseRepeatOutput == $past(diffLevel))
    else $error("repeat output differs from input");
  loop_none_a: assert property (muxOutQ == OUT_LOOP && muxInQ == IN_NONE
    |=> !pulseRepeatOutput)
    else $error("loop output active with no input");
  master_pulse_a: assert property (muxOutQ == OUT_MASTER && secCarry
    ##1 muxOutQ == OUT_MASTER |-> pulseRepeatOutput ##1 pulseRepeatOutput)
    else $error("master pulse missing after second carry");
  set_keeps_mux_a: assert property (setCmd && !resetCmd
    |=> secsQ == $past(setSecsQ) && muxInQ == $past(muxInQ) && muxOutQ == $past(muxOutQ))
    else $error("set command wrong");
  full_reset_a: assert property (resetCmd
    |=> muxInQ == IN_DIFF && muxOutQ == OUT_NONE && !syncedQ && fracQ == $past(setFracQ))
    else $error("full reset wrong");
  thresh_default_a: assert property ($past(rst) |-> threshQ == THRESH_DEFAULT)
    else $error("threshold default wrong");
  bad_count_a: assert property (incBad && !clearCmd && !resetCmd
    |=> badCntQ == $past(badCntQ) + 32'h1 && !syncedQ)
    else $error("bad pulse not counted");
  resync_lock_a: assert property (stepNow && !resetCmd && !setCmd && !clearCmd
    |=> syncedQ && resyncCntQ == $past(resyncCntQ) + 32'h1 && fracQ < 32'h0000_1000)
    else $error("resync did not lock");

  lock_good_c: cover property (refEvt && syncedQ && !badPulse);
  bad_pulse_c: cover property (incBad);
  master_out_c: cover property (muxOutQ == OUT_MASTER && pulseRepeatOutput);
  tail_stamp_c: cover property (tailSelQ && pktTail);

endmodule // ptcs_top

`default_nettype wire

// *** ptcs_pps_src.sv ***
// partner model: pulse-per-second time receiver driving sync circuit A
`timescale 1ns/1ps
`default_nettype none

module ptcs_pps_src (
  input  wire logic        fire,
  input  wire logic [15:0] delayNs,
  output var  logic        pps
);
  // answers each request after delayNs; line rests low between pulses (fail-safe bias)
  initial pps = 1'b0;
  always @(posedge fire) begin
    #(delayNs);
    pps = 1'b1;
    #1000;       // 1 us pulse: long enough for any synchroniser
    pps = 1'b0;
  end
endmodule // ptcs_pps_src

`default_nettype wire

// *** ptcs_tb_top.sv ***
// testbench: register, stamp, discipline and sync-output checks of the stamp clock
`timescale 1ns/1ps
`default_nettype none

module ptcs_tb_top import ptcs_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        pktHead = 1'b0;
  logic        pktTail = 1'b0;
  logic        fire    = 1'b0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, stampValid, pulseRepeatOutput, pulseRepeatOutputEn, irq;
  logic        pps, sv;
  ptcs_stamp_t stampData, sd;
  int          miscompares = 0;
  int          checked     = 0;

  // 250 MHz reference clock
  always #2 ref_clk = ~ref_clk;

  ptcs_top #(.ZERO_BITS(4), .LOSS_CYCLES(2000)) dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pktHead(pktHead),
    .pktTail(pktTail), .stampData(stampData), .stampValid(stampValid),
    .differentialPulseInput(pps), .pulseRepeatOutput(pulseRepeatOutput),
    .pulseRepeatOutputEn(pulseRepeatOutputEn), .irq(irq));

  ptcs_pps_src src (.fire(fire), .delayNs(16'h25), .pps(pps));

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // one single transfer, entered just after a rising edge; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, {32'h0, e}, {32'h0, rd});
  endtask

  // one-cycle packet pulse; the stamp is caught in the cycle after it is taken
  task automatic pkt(input logic h, input logic t);
    pktHead <= h;
    pktTail <= t;
    @(posedge ref_clk);
    pktHead <= 1'b0;
    pktTail <= 1'b0;
    #1;
    sv = stampValid;
    sd = stampData;
    @(posedge ref_clk);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk("ctrl", OFS_CTRL, 32'h0);
    chk("outEn", 64'h0, pulseRepeatOutputEn);
    chk("hresp", 64'h0, hresp);
    rdchk("thresh", OFS_THRESH, THRESH_DEFAULT);
    rdchk("incr", OFS_INCR, INCR_DEFAULT);
    rdchk("hole", 8'hfc, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h4);
    bus(1'b1, OFS_SET_SECS, 32'h1234_5678);
    bus(1'b1, OFS_SET_FRAC, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h104);
    rdchk("ctrlKept", OFS_CTRL, 32'h4);
    rdchk("secs", OFS_TIME_SEC, 32'h1234_5678);
    pkt(1'b1, 1'b0);
    chk("headV", 64'h1, sv);
    chk("headSecs", 64'h1234_5678, sd.secs);
    chk("headLow", 64'h0, sd.frac[3:0]);
    bus(1'b1, OFS_CTRL, 32'h14);
    pkt(1'b1, 1'b0);
    chk("tailIgnHead", 64'h0, sv);
    pkt(1'b0, 1'b1);
    chk("tailV", 64'h1, sv);
    chk("tailSecs", 64'h1234_5678, sd.secs);
    // reference pulse while repeating: lock, count and interrupt
    bus(1'b1, OFS_IRQ_EN, 32'h1);
    fire <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("rptOut", 64'h1, pulseRepeatOutput);
    chk("rptEn", 64'h1, pulseRepeatOutputEn);
    chk("irqUp", 64'h1, irq);
    rdchk("synced", OFS_STATUS, 32'h1);
    rdchk("total", OFS_TOTAL, 32'h1);
    rdchk("resync", OFS_RESYNC, 32'h1);
    rdchk("irqStat", OFS_IRQ_STAT, 32'h5);
    bus(1'b1, OFS_IRQ_CLR, 32'hf);
    bus(1'b1, OFS_IRQ_EN, 32'h8);
    fire <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irqClr", 64'h0, irq);
    // no further reference: lock is lost after the shortened timeout
    repeat (2100) @(posedge ref_clk);
    rdchk("lost", OFS_STATUS, 32'h0);
    chk("irqLost", 64'h1, irq);
    rdchk("irqStat", OFS_IRQ_STAT, 32'h8);
    // internal host-tracking source, output looped
    bus(1'b1, OFS_CTRL, 32'h9);
    bus(1'b1, OFS_CTRL, 32'h809);
    repeat (3) @(posedge ref_clk);
    chk("loopOut", 64'h1, pulseRepeatOutput);
    rdchk("total2", OFS_TOTAL, 32'h2);
    // a tick a few cycles later is good; one 300 cycles later is far past 596 ns
    bus(1'b1, OFS_CTRL, 32'h809);
    rdchk("badNone", OFS_BAD, 32'h0);
    repeat (300) @(posedge ref_clk);
    bus(1'b1, OFS_CTRL, 32'h809);
    rdchk("bad", OFS_BAD, 32'h1);
    rdchk("badUnlock", OFS_STATUS, 32'h0);
    rdchk("total3", OFS_TOTAL, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h409);
    rdchk("badClr", OFS_BAD, 32'h0);
    rdchk("totalClr", OFS_TOTAL, 32'h0);
    // master pulse follows the seconds carry
    bus(1'b1, OFS_CTRL, 32'he);
    bus(1'b1, OFS_SET_SECS, 32'hff);
    bus(1'b1, OFS_SET_FRAC, 32'hffff_f000);
    bus(1'b1, OFS_CTRL, 32'h10e);
    repeat (300) @(posedge ref_clk);
    chk("master", 64'h1, pulseRepeatOutput);
    rdchk("carry", OFS_TIME_SEC, 32'h100);
    bus(1'b1, OFS_CTRL, 32'h200);
    repeat (2) @(posedge ref_clk);
    rdchk("ctrlRst", OFS_CTRL, 32'h0);
    chk("enRst", 64'h0, pulseRepeatOutputEn);
    bus(1'b1, OFS_CTRL, 32'h4);
    report_and_stop();
  end

  // watchdog: tests need about 2800 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule // ptcs_tb_top

`default_nettype wire
